/* File: actuator_measure_pkg.sv */
// constants, register map and carrier types of the actuator measure and drive register bank
package actuator_measure_pkg;

    // ====================================================================
    // register offsets
    localparam logic [7:0] ADDR_CONT_CTRL   = 8'h48;
    localparam logic [7:0] ADDR_DETECT_CTRL = 8'h5f;
    localparam logic [7:0] ADDR_RESIST      = 8'h60;
    localparam logic [7:0] ADDR_OFFSET      = 8'h61;
    localparam logic [7:0] ADDR_SUPPLY      = 8'h62;
    localparam logic [7:0] ADDR_CONV_TEST   = 8'h66;
    localparam logic [7:0] ADDR_DET_PER_HI  = 8'h68;
    localparam logic [7:0] ADDR_DET_PER_LO  = 8'h69;
    localparam logic [7:0] ADDR_TRK_PER_HI  = 8'h6a;
    localparam logic [7:0] ADDR_TRK_PER_LO  = 8'h6b;
    localparam logic [7:0] ADDR_UPPER_LIM   = 8'h72;
    localparam logic [7:0] ADDR_LOWER_LIM   = 8'h73;
    localparam logic [7:0] ADDR_PLAY_DUR    = 8'h79;
    localparam logic [7:0] ADDR_NZC_TIMEOUT = 8'h7a;
    localparam logic [7:0] ADDR_NORM_AMP    = 8'h7b;
    localparam logic [7:0] ADDR_OV_AMP      = 8'h7c;

    // ====================================================================
    // reset values
    localparam logic [7:0]  RST_CONT_CTRL   = 8'h98;
    localparam logic [7:0]  RST_DETECT_CTRL = 8'h00;
    localparam logic [7:0]  RST_RESIST      = 8'h00;
    localparam logic [7:0]  RST_OFFSET      = 8'h80;
    localparam logic [7:0]  RST_SUPPLY      = 8'h00;
    localparam logic [7:0]  RST_CONV_TEST   = 8'h00;
    localparam logic [15:0] RST_PERIOD      = 16'h0000;
    localparam logic [7:0]  RST_UPPER_LIM   = 8'h0f;
    localparam logic [7:0]  RST_LOWER_LIM   = 8'hf1;
    localparam logic [7:0]  RST_PLAY_DUR    = 8'h3f;
    localparam logic [7:0]  RST_NZC_TIMEOUT = 8'h1f;
    localparam logic [7:0]  RST_NORM_AMP    = 8'h50;
    localparam logic [7:0]  RST_OV_AMP      = 8'h7f;

    // ====================================================================
    // field positions
    localparam int DIAG_TRIG_BIT   = 0;
    localparam int SUPPLY_TRIG_BIT = 1;
    localparam int TARGET_SEL_BIT  = 6;
    localparam int RES_DET_EN_BIT  = 2;
    localparam int COMP_SEL_BIT    = 6;

    // ====================================================================
    // timing: times in ns, counts in 25 ns cycles (rounded down)
    localparam real CLK_PERIOD_NS  = 25.0;
    localparam real PERIOD_LSB_NS  = 2600.0;
    localparam real PLAY_UNIT_NS   = 5333300.0;
    localparam real NZC_UNIT_NS    = 166670.0;
    localparam int  PERIOD_LSB_CYC = $rtoi(PERIOD_LSB_NS / CLK_PERIOD_NS + 0.001);
    localparam int  PLAY_UNIT_CYC  = $rtoi(PLAY_UNIT_NS / CLK_PERIOD_NS + 0.001);
    localparam int  NZC_UNIT_CYC   = $rtoi(NZC_UNIT_NS / CLK_PERIOD_NS + 0.001);
    localparam logic [6:0] PERIOD_LSB_LAST = 7'(PERIOD_LSB_CYC - 1);

    // ====================================================================
    // carrier types
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } regReq_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sample_type;

    typedef struct packed {
        logic [7:0]  contCtrl;
        logic [7:0]  detectCtrl;
        logic [7:0]  resist;
        logic [7:0]  offset;
        logic [7:0]  supply;
        logic [7:0]  convTest;
        logic [15:0] detPeriod;
        logic [15:0] trkPeriod;
        logic [7:0]  upperLim;
        logic [7:0]  lowerLim;
        logic [7:0]  playDur;
        logic [7:0]  nzcTimeout;
        logic [7:0]  normAmp;
        logic [7:0]  ovAmp;
        logic [6:0]  lsbPre;
        logic [15:0] periodCnt;
        logic        seenCross;
        logic [7:0]  rdData;
        logic [7:0]  ampLevel;
        logic        playExpired;
        logic        noCrossing;
    } bankState_type;

endpackage

/* File: zero_pass_detector.sv */
// back-emf zero crossing detector with programmable upper and lower limits
`timescale 1ns/1ps
module zero_pass_detector
    import actuator_measure_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstSync_n,
    input  wire logic       ce,
    input  wire sample_type bemf,
    input  wire logic [7:0] upperLimit,
    input  wire logic [7:0] lowerLimit,
    output logic            posCross,
    output logic            negCross
);

    typedef struct packed {
        logic isPositive;
        logic posCross;
        logic negCross;
    } zpState_type;

    zpState_type state_r;
    zpState_type state_nxt;
    logic        aboveUpper;
    logic        belowLower;

    // signed comparisons against the two limits
    assign aboveUpper = $signed(bemf.data) > $signed(upperLimit);
    assign belowLower = $signed(bemf.data) < $signed(lowerLimit);

    // a crossing only counts once the sample leaves the dead band
    always_comb begin
        state_nxt          = state_r;
        state_nxt.posCross = 1'b0;
        state_nxt.negCross = 1'b0;
        if (bemf.valid) begin
            if (!state_r.isPositive && aboveUpper) begin
                state_nxt.isPositive = 1'b1;
                state_nxt.posCross   = 1'b1;
            end
            if (state_r.isPositive && belowLower) begin
                state_nxt.isPositive = 1'b0;
                state_nxt.negCross   = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign posCross = state_r.posCross;
    assign negCross = state_r.negCross;

    upper_cross_a: assert property (@(posedge clk) disable iff (!rstSync_n)
        ce && bemf.valid && !state_r.isPositive && aboveUpper |=> posCross && !negCross)
        else $error("positive crossing not flagged");
    lower_cross_a: assert property (@(posedge clk) disable iff (!rstSync_n)
        ce && bemf.valid && state_r.isPositive && belowLower |=> negCross && !posCross)
        else $error("negative crossing not flagged");

endmodule

/* File: unit_timer.sv */
// timer counting whole units of UNIT_CYC cycles up to an 8-bit limit
`timescale 1ns/1ps
module unit_timer
    import actuator_measure_pkg::*;
#(
    parameter int UNIT_CYC = 16
)
(
    input  wire logic       clk,
    input  wire logic       rstSync_n,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [7:0] limit,
    output logic            expired
);

    localparam int PW = $clog2(UNIT_CYC + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYC - 1);

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [7:0]    units;
        logic          expired;
    } timerState_type;

    timerState_type state_r;
    timerState_type state_nxt;

    // units advance while running; restart or stop clears the count
    always_comb begin
        state_nxt = state_r;
        if (!run || restart) begin
            state_nxt = '0;
        end else if (state_r.units >= limit) begin
            state_nxt.expired = 1'b1;
        end else if (state_r.pre == PRE_LAST) begin
            state_nxt.pre   = '0;
            state_nxt.units = state_r.units + 8'h01;
        end else begin
            state_nxt.pre = state_r.pre + PW'(1);
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign expired = state_r.expired;

    unit_limit_a: assert property (@(posedge clk) disable iff (!rstSync_n)
        $rose(expired) |-> $past(state_r.units) >= $past(limit) && $past(run))
        else $error("timer expired before its limit");

endmodule

/* File: actuator_measure_drive_regs.sv */
// register bank with diagnostic results, resonance periods and drive settings
`timescale 1ns/1ps

// Contract
// - the actuator resistance from the diagnostic run reads as an 8-bit value, zero after reset.
// - the offset from the offset diagnostic reads as an 8-bit value, 0x80 after reset.
// - the supply voltage from the supply run reads as an 8-bit value, zero after reset.
// - bit 6 of the converter test register picks software (0) or hardware (1) compensation.
// - resonance detection stores its 16-bit period in 2.6 us steps as high and low bytes.
// - continuous drive keeps its own 16-bit tracked period in 2.6 us steps.
// - a positive crossing counts only once back-emf passes the upper limit, default 0x0f.
// - a negative crossing counts only once back-emf passes the lower limit, default 0xf1.
// - play time in open or closed loop is limited to the duration times 5333.3 us, default 0x3f.
// - no crossing for the timeout setting times 166.67 us raises no-crossing, default 0x1f.
// - normal drive amplitude follows an 8-bit setting, default 0x50.
// - overdrive amplitude follows a separate 8-bit setting, default 0x7f.
// - setting the diagnostic trigger bit 0 starts a diagnostic that yields its result.
// - the target select bit 6 picks resistance (1) or converter offset (0).
// - setting supply trigger bit 1 starts a supply measurement that updates its result.
// - the detected resonance period is stored only while enable bit 2 is set, default 0.
module actuator_measure_drive_regs
    import actuator_measure_pkg::*;
#(
    parameter int PLAY_CYC = PLAY_UNIT_CYC,
    parameter int NZC_CYC  = NZC_UNIT_CYC
)
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire regReq_type hostReq,
    input  wire sample_type convSample,
    input  wire sample_type bemfSample,
    input  wire logic       driveActive,
    input  wire logic       overdrive,
    output logic [7:0]      rdData,
    output logic [7:0]      ampLevel,
    output logic            compHwSel,
    output logic            diagBusy,
    output logic            supplyBusy,
    output logic            playExpired,
    output logic            noCrossing
);

    // ====================================================================
    // reset release
    logic rstMeta_r;
    logic rstSync_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_n <= rstMeta_r;
        end
    end

    // ====================================================================
    // read decode
    function automatic logic [7:0] regRead(input logic [7:0] addr, input bankState_type s);
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            ADDR_CONT_CTRL:   value = s.contCtrl;
            ADDR_DETECT_CTRL: value = s.detectCtrl;
            ADDR_RESIST:      value = s.resist;
            ADDR_OFFSET:      value = s.offset;
            ADDR_SUPPLY:      value = s.supply;
            ADDR_CONV_TEST:   value = s.convTest;
            ADDR_DET_PER_HI:  value = s.detPeriod[15:8];
            ADDR_DET_PER_LO:  value = s.detPeriod[7:0];
            ADDR_TRK_PER_HI:  value = s.trkPeriod[15:8];
            ADDR_TRK_PER_LO:  value = s.trkPeriod[7:0];
            ADDR_UPPER_LIM:   value = s.upperLim;
            ADDR_LOWER_LIM:   value = s.lowerLim;
            ADDR_PLAY_DUR:    value = s.playDur;
            ADDR_NZC_TIMEOUT: value = s.nzcTimeout;
            ADDR_NORM_AMP:    value = s.normAmp;
            ADDR_OV_AMP:      value = s.ovAmp;
            default:          value = 8'h00;
        endcase
        return value;
    endfunction

    // ====================================================================
    // state
    bankState_type state_r;
    bankState_type state_nxt;
    logic          posCross;
    logic          negCross;
    logic          playDone;
    logic          nzcDone;
    logic          anyCross;
    logic          diagDone;
    logic          supplyDone;

    assign anyCross   = posCross | negCross;
    assign diagDone   = state_r.detectCtrl[DIAG_TRIG_BIT] & convSample.valid;
    assign supplyDone = state_r.detectCtrl[SUPPLY_TRIG_BIT] & convSample.valid
                        & ~state_r.detectCtrl[DIAG_TRIG_BIT];

    // ====================================================================
    // submodules
    // limits feed the detector
    zero_pass_detector zeroPass (
        .clk        (clk),
        .rstSync_n  (rstSync_n),
        .ce         (ce),
        .bemf       (bemfSample),
        .upperLimit (state_r.upperLim),
        .lowerLimit (state_r.lowerLim),
        .posCross   (posCross),
        .negCross   (negCross)
    );

    unit_timer #(.UNIT_CYC(PLAY_CYC)) playTimer (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .ce        (ce),
        .run       (driveActive),
        .restart   (1'b0),
        .limit     (state_r.playDur),
        .expired   (playDone)
    );

    unit_timer #(.UNIT_CYC(NZC_CYC)) nzcTimer (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .ce        (ce),
        .run       (driveActive),
        .restart   (anyCross),
        .limit     (state_r.nzcTimeout),
        .expired   (nzcDone)
    );

    // ====================================================================
    // next state
    always_comb begin
        state_nxt             = state_r;
        state_nxt.playExpired = playDone;
        state_nxt.noCrossing  = nzcDone;

        state_nxt.ampLevel = state_r.normAmp;
        if (overdrive) begin
            state_nxt.ampLevel = state_r.ovAmp;
        end

        if (hostReq.rd) begin
            state_nxt.rdData = regRead(hostReq.addr, state_r);
        end

        // diagnostic sample goes to the selected result
        if (diagDone) begin
            if (state_r.detectCtrl[TARGET_SEL_BIT]) begin
                state_nxt.resist = convSample.data;
            end else begin
                state_nxt.offset = convSample.data;
            end
            state_nxt.detectCtrl[DIAG_TRIG_BIT] = 1'b0;
        end

        // supply sample, after any pending diagnostic
        if (supplyDone) begin
            state_nxt.supply = convSample.data;
            state_nxt.detectCtrl[SUPPLY_TRIG_BIT] = 1'b0;
        end

        // 2.6 us period prescaler and saturating period counter
        if (state_r.lsbPre == PERIOD_LSB_LAST) begin
            state_nxt.lsbPre = 7'h00;
            if (state_r.periodCnt != 16'hffff) begin
                state_nxt.periodCnt = state_r.periodCnt + 16'h0001;
            end
        end else begin
            state_nxt.lsbPre = state_r.lsbPre + 7'h01;
        end

        // period between positive crossings
        if (posCross) begin
            state_nxt.periodCnt = 16'h0000;
            state_nxt.lsbPre    = 7'h00;
            state_nxt.seenCross = 1'b1;
            if (state_r.seenCross) begin
                if (state_r.contCtrl[RES_DET_EN_BIT]) begin
                    state_nxt.detPeriod = state_r.periodCnt;
                end
                if (driveActive) begin
                    state_nxt.trkPeriod = state_r.periodCnt;
                end
            end
        end
        if (!driveActive && !state_r.contCtrl[RES_DET_EN_BIT]) begin
            state_nxt.seenCross = 1'b0;
        end

        // host writes; a new trigger wins over completion
        if (hostReq.wr) begin
            case (hostReq.addr)
                ADDR_CONT_CTRL:   state_nxt.contCtrl   = hostReq.wdata;
                ADDR_DETECT_CTRL: state_nxt.detectCtrl = hostReq.wdata;
                ADDR_CONV_TEST:   state_nxt.convTest   = hostReq.wdata;
                ADDR_UPPER_LIM:   state_nxt.upperLim   = hostReq.wdata;
                ADDR_LOWER_LIM:   state_nxt.lowerLim   = hostReq.wdata;
                ADDR_PLAY_DUR:    state_nxt.playDur    = hostReq.wdata;
                ADDR_NZC_TIMEOUT: state_nxt.nzcTimeout = hostReq.wdata;
                ADDR_NORM_AMP:    state_nxt.normAmp    = hostReq.wdata;
                ADDR_OV_AMP:      state_nxt.ovAmp      = hostReq.wdata;
                default:          ; // results are read-only
            endcase
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_r             <= '0;
            state_r.contCtrl    <= RST_CONT_CTRL;
            state_r.detectCtrl  <= RST_DETECT_CTRL;
            state_r.resist      <= RST_RESIST;
            state_r.offset      <= RST_OFFSET;
            state_r.supply      <= RST_SUPPLY;
            state_r.convTest    <= RST_CONV_TEST;
            state_r.detPeriod   <= RST_PERIOD;
            state_r.trkPeriod   <= RST_PERIOD;
            state_r.upperLim    <= RST_UPPER_LIM;
            state_r.lowerLim    <= RST_LOWER_LIM;
            state_r.playDur     <= RST_PLAY_DUR;
            state_r.nzcTimeout  <= RST_NZC_TIMEOUT;
            state_r.normAmp     <= RST_NORM_AMP;
            state_r.ovAmp       <= RST_OV_AMP;
            state_r.ampLevel    <= RST_NORM_AMP;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ====================================================================
    // outputs, all straight from the state register
    assign rdData      = state_r.rdData;
    assign ampLevel    = state_r.ampLevel;
    assign compHwSel   = state_r.convTest[COMP_SEL_BIT];
    assign diagBusy    = state_r.detectCtrl[DIAG_TRIG_BIT];
    assign supplyBusy  = state_r.detectCtrl[SUPPLY_TRIG_BIT];
    assign playExpired = state_r.playExpired;
    assign noCrossing  = state_r.noCrossing;

    // ====================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_n);

    logic quietWr;
    assign quietWr = !(hostReq.wr && hostReq.addr == ADDR_DETECT_CTRL);

    sequence diagArm;
        ce && hostReq.wr && hostReq.addr == ADDR_DETECT_CTRL && hostReq.wdata[DIAG_TRIG_BIT];
    endsequence

    sequence diagSample;
        ce && diagDone && quietWr;
    endsequence

    diag_start_a: assert property (diagArm |=> diagBusy)
        else $error("diagnostic trigger not armed");
    resist_capture_a: assert property (
        diagSample and state_r.detectCtrl[TARGET_SEL_BIT]
        |=> state_r.resist == $past(convSample.data) && !diagBusy)
        else $error("resistance result not captured");
    offset_capture_a: assert property (
        diagSample and !state_r.detectCtrl[TARGET_SEL_BIT]
        |=> state_r.offset == $past(convSample.data) && $stable(state_r.resist))
        else $error("offset result not captured");
    supply_capture_a: assert property (
        ce && supplyDone && quietWr |=> state_r.supply == $past(convSample.data) && !supplyBusy)
        else $error("supply result not captured");
    comp_select_a: assert property (
        ce && hostReq.wr && hostReq.addr == ADDR_CONV_TEST
        |=> compHwSel == $past(hostReq.wdata[COMP_SEL_BIT]))
        else $error("compensation select not written");
    detect_period_a: assert property (
        ce && posCross && state_r.seenCross && state_r.contCtrl[RES_DET_EN_BIT]
        |=> state_r.detPeriod == $past(state_r.periodCnt))
        else $error("detected period not stored");
    track_period_a: assert property (
        ce && posCross && state_r.seenCross && driveActive
        |=> state_r.trkPeriod == $past(state_r.periodCnt))
        else $error("tracked period not stored");
    detect_gate_a: assert property (
        !state_r.contCtrl[RES_DET_EN_BIT] ##1 !state_r.contCtrl[RES_DET_EN_BIT]
        |-> $stable(state_r.detPeriod))
        else $error("period detected while disabled");
    amp_select_a: assert property (
        ce |=> ampLevel == ($past(overdrive) ? $past(state_r.ovAmp) : $past(state_r.normAmp)))
        else $error("drive amplitude mismatch");
    ro_ignore_a: assert property (
        ce && hostReq.wr && hostReq.addr == ADDR_RESIST && !diagDone |=> $stable(state_r.resist))
        else $error("read-only result was written");
    nzc_flag_a: assert property (
        ce && !driveActive ##1 ce |=> !noCrossing)
        else $error("no-crossing flag outside drive");

endmodule

/* File: actuator_model.sv */
// far side model: converter and back-emf sources answering three edges after a request
`timescale 1ns/1ps
module actuator_model
    import actuator_measure_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] level,
    input  wire logic       toBemf,
    output sample_type      convSample = '0,
    output sample_type      bemfSample = '0
);
    logic [1:0] delay_r = '0;

    // ====================================================================
    // measured value source
    // one valid pulse per request, data inverted between pulses
    always_ff @(posedge clk) begin
        delay_r    <= {delay_r[0], go};
        convSample <= {delay_r[1] & ~toBemf, delay_r[1] ? level : ~convSample.data};
        bemfSample <= {delay_r[1] & toBemf, delay_r[1] ? level : ~bemfSample.data};
    end
endmodule

/* File: actuator_measure_drive_regs_test.sv */
// self-checking testbench of the actuator measure and drive register bank
`timescale 1ns/1ps
module actuator_measure_drive_regs_test;
    import actuator_measure_pkg::*;
    logic       clk = 0, rst_n = 0, driveActive = 0, overdrive = 0, go = 0, toBemf = 0, ce = 1;
    logic [7:0] level = '0, rdData, ampLevel;
    logic       compHwSel, diagBusy, supplyBusy, playExpired, noCrossing;
    regReq_type hostReq = '0;
    sample_type convSample, bemfSample;
    int         errorCnt = 0, nCompared = 0;
    logic [7:0] ra[15] = '{8'h60, 8'h61, 8'h62, 8'h66, 8'h68, 8'h69, 8'h6a, 8'h6b,
                           8'h72, 8'h73, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h50};
    logic [7:0] rv[15] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h0f, 8'hf1, 8'h3f, 8'h1f, 8'h50, 8'h7f, 8'h00};
    logic [14:0] rw = 15'b000100001111110;

    actuator_measure_drive_regs #(.PLAY_CYC(4), .NZC_CYC(4)) actuator_measure_drive_regs_inst (
        .clk(clk), .rst_n(rst_n), .ce(ce), .hostReq(hostReq), .convSample(convSample),
        .bemfSample(bemfSample), .driveActive(driveActive), .overdrive(overdrive),
        .rdData(rdData), .ampLevel(ampLevel), .compHwSel(compHwSel), .diagBusy(diagBusy),
        .supplyBusy(supplyBusy), .playExpired(playExpired), .noCrossing(noCrossing));
    actuator_model actuator_model_inst (.clk(clk), .go(go), .level(level), .toBemf(toBemf),
        .convSample(convSample), .bemfSample(bemfSample));

    // clock generator
    always #12.5 clk = ~clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one host access, read data is settled on return
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk);
        hostReq <= '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
        @(posedge clk);
        hostReq <= '0;
        #1;
    endtask

    task automatic stim(input logic bemf, input logic [7:0] lvl);
        @(posedge clk);
        go <= 1'b1;
        level <= lvl;
        toBemf <= bemf;
        @(posedge clk);
        go <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic t_regs;
        for (int i = 0; i < 15; i++) begin
            access(0, ra[i], 8'h00);
            check(rdData, rv[i]);
            access(1, ra[i], 8'ha5);
            access(0, ra[i], 8'h00);
            check(rdData, rw[14 - i] ? 8'ha5 : rv[i]);
        end
    endtask

    task automatic t_amp;
        access(1, 8'h7b, 8'h33);
        @(posedge clk);
        #1;
        check(ampLevel, 8'h33);
        // a write while the clock enable is low must not land
        @(posedge clk);
        ce <= 1'b0;
        overdrive <= 1'b1;
        access(1, 8'h7b, 8'h44);
        @(posedge clk);
        ce <= 1'b1;
        #1;
        check(ampLevel, 8'h33);
        access(1, 8'h66, 8'h40);
        @(posedge clk);
        #1;
        check(ampLevel, 8'ha5);
        check({7'h0, compHwSel}, 8'h01);
        access(0, 8'h7b, 8'h00);
        check(rdData, 8'h33);
        @(posedge clk);
        overdrive <= 1'b0;
    endtask

    task automatic t_diag(input logic [7:0] ctrl, input logic [7:0] lvl, input logic [7:0] a);
        access(1, 8'h5f, ctrl);
        check({7'h0, diagBusy | supplyBusy}, 8'h01);
        stim(0, lvl);
        check({6'h0, diagBusy, supplyBusy}, 8'h00);
        access(0, a, 8'h00);
        check(rdData, lvl);
    endtask

    task automatic t_period;
        access(1, 8'h72, 8'h0f);
        access(1, 8'h73, 8'hf1);
        access(1, 8'h48, 8'h9c);
        stim(1, 8'hec);
        stim(1, 8'h14);
        repeat (312) @(posedge clk);
        driveActive <= 1'b1;
        stim(1, 8'hec);
        stim(1, 8'h14);
        access(0, 8'h69, 8'h00);
        check(rdData, 8'h03);
        access(0, 8'h6b, 8'h00);
        check(rdData, 8'h03);
        // detection off, drive on: only the tracked period moves
        access(1, 8'h48, 8'h98);
        stim(1, 8'hec);
        stim(1, 8'h14);
        access(0, 8'h69, 8'h00);
        check(rdData, 8'h03);
        access(0, 8'h6b, 8'h00);
        check(rdData, 8'h00);
        @(posedge clk);
        driveActive <= 1'b0;
    endtask

    task automatic t_timers;
        access(1, 8'h79, 8'h02);
        access(1, 8'h7a, 8'h02);
        @(posedge clk);
        driveActive <= 1'b1;
        repeat (9) @(posedge clk);
        #1;
        check({6'h0, playExpired, noCrossing}, 8'h00);
        @(posedge clk);
        #1;
        check({6'h0, playExpired, noCrossing}, 8'h03);
        @(posedge clk);
        driveActive <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check({6'h0, playExpired, noCrossing}, 8'h00);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk);
        errorCnt++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(ampLevel, 8'h50);
        t_regs();
        t_amp();
        t_diag(8'h41, 8'h22, 8'h60);
        t_diag(8'h01, 8'h33, 8'h61);
        t_diag(8'h02, 8'h44, 8'h62);
        t_period();
        t_timers();
        close_out();
    end
endmodule
